// ---- logic/dpg_generator.sv ----
// Notes on behaviour
// - enable bit 0 starts generation when set, stops when cleared; bits 31:1 reserved
// - select bit 0 gives PRBS-7 taps 7,6; bit 1 gives PRBS-15 taps 15,14
// - select bit 2 gives PRBS-23 taps 23,18; bit 3 gives PRBS-31 taps 31,28
// - select bit 4 gives constant alternating zero-one word every beat
// - select bit 5 gives per-symbol half ones then half zeros
// - while enabled only enable and inject registers accept writes
// - first valid beat appears on fourth cycle after enable is set
// - after enable clears, the final output shows at the next cycle
// - inject bit 0 adds one bit error; self-clears next cycle when enabled
// - lsb of beat inverts four cycles after inject, unless beat is backpressured
// - disabling within two cycles of inject may drop the corrupted beat
// - with preamble on, preamble word goes first for programmed count of beats
// - preamble count in control bits 15:8; bits 7:1 and 31:16 reserved
// - low character register gives preamble bits 31:0
// - high character bits 7:0 give preamble bits 39:32; unused at width 32
// - enable and inject cross to stream side through sync of depth at least 2; other registers are used directly
`timescale 1ns/1ns
`default_nettype none
module dpg_generator
	import dpg_pkg::*;
#(
	parameter int sync_stage_depth = SYNC_DEPTH
) (
	// clock, reset, enable
	input  wire logic                core_clk,
	input  wire logic                rst_n,
	input  wire logic                clk_en,
	// register port
	input  wire logic [REG_AW-1:0]   reg_addr,
	input  wire logic                reg_write,
	input  wire logic [REG_DW-1:0]   reg_wdata,
	input  wire logic                reg_read,
	output logic      [REG_DW-1:0]   reg_rdata,
	// pattern stream
	output logic      [STREAM_W-1:0] stream_data,
	output logic                     stream_valid,
	input  wire logic                stream_ready
);

	// advances the lfsr one beat; returns {next state, beat word}, msb first
	function automatic logic [LFSR_W+STREAM_W-1:0] prbs_beat(input logic [LFSR_W-1:0] st, input int len,
		input int tap);
		logic [LFSR_W-1:0]   s;
		logic [STREAM_W-1:0] w;
		logic                fb;
		s = st;
		w = '0;
		for (int i = STREAM_W - 1; i >= 0; i--) begin
			fb = s[len-1] ^ s[tap-1];
			s = {s[LFSR_W-2:0], fb};
			w[i] = fb;
		end
		return {s, w};
	endfunction

	// register group
	logic                  gen_en_ff, nxt_gen_en;
	logic [PAT_W-1:0]      pat_sel_ff, nxt_pat_sel;
	logic                  inj_ff, nxt_inj;
	logic                  pre_on_ff, nxt_pre_on;
	logic [PRE_CNT_W-1:0]  pre_cfg_ff, nxt_pre_cfg;
	logic [REG_DW-1:0]     pchar_lo_ff, nxt_pchar_lo;
	logic [PCHAR_HI_W-1:0] pchar_hi_ff, nxt_pchar_hi;
	logic [REG_DW-1:0]     rdata_ff, nxt_rdata;
	logic                  wr_ok;
	logic                  inj_launch;

	always_comb begin
		nxt_gen_en   = gen_en_ff;
		nxt_pat_sel  = pat_sel_ff;
		nxt_pre_on   = pre_on_ff;
		nxt_pre_cfg  = pre_cfg_ff;
		nxt_pchar_lo = pchar_lo_ff;
		nxt_pchar_hi = pchar_hi_ff;
		nxt_rdata    = rdata_ff;
		// inject only fires while enabled; a disabled core keeps it pending
		inj_launch   = inj_ff & gen_en_ff;
		nxt_inj      = inj_launch ? 1'b0 : inj_ff;
		wr_ok        = !gen_en_ff || reg_addr == OFS_ENABLE || reg_addr == OFS_INJECT;
		if (reg_write && wr_ok) begin
			if (reg_addr == OFS_ENABLE) begin
				nxt_gen_en = reg_wdata[EN_BIT];
			end else if (reg_addr == OFS_PATTERN) begin
				nxt_pat_sel = reg_wdata[PAT_W-1:0];
			end else if (reg_addr == OFS_INJECT) begin
				// a write in the clearing cycle wins over the self-clear
				nxt_inj = reg_wdata[INJ_BIT];
			end else if (reg_addr == OFS_PRE_CTRL) begin
				nxt_pre_on  = reg_wdata[PRE_ON_BIT];
				nxt_pre_cfg = reg_wdata[PRE_CNT_LSB +: PRE_CNT_W];
			end else if (reg_addr == OFS_PCHAR_LO) begin
				nxt_pchar_lo = reg_wdata;
			end else if (reg_addr == OFS_PCHAR_HI) begin
				nxt_pchar_hi = reg_wdata[PCHAR_HI_W-1:0];
			end
		end
		if (reg_read) begin
			nxt_rdata = '0;
			if (reg_addr == OFS_ENABLE) begin
				nxt_rdata[EN_BIT] = gen_en_ff;
			end else if (reg_addr == OFS_PATTERN) begin
				nxt_rdata[PAT_W-1:0] = pat_sel_ff;
			end else if (reg_addr == OFS_INJECT) begin
				nxt_rdata[INJ_BIT] = inj_ff;
			end else if (reg_addr == OFS_PRE_CTRL) begin
				nxt_rdata[PRE_ON_BIT] = pre_on_ff;
				nxt_rdata[PRE_CNT_LSB +: PRE_CNT_W] = pre_cfg_ff;
			end else if (reg_addr == OFS_PCHAR_LO) begin
				nxt_rdata = pchar_lo_ff;
			end else if (reg_addr == OFS_PCHAR_HI) begin
				nxt_rdata[PCHAR_HI_W-1:0] = pchar_hi_ff;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			gen_en_ff   <= 1'b0;
			pat_sel_ff  <= '0;
			inj_ff      <= 1'b0;
			pre_on_ff   <= 1'b0;
			pre_cfg_ff  <= '0;
			pchar_lo_ff <= '0;
			pchar_hi_ff <= '0;
			rdata_ff    <= '0;
		end else if (clk_en) begin
			gen_en_ff   <= nxt_gen_en;
			pat_sel_ff  <= nxt_pat_sel;
			inj_ff      <= nxt_inj;
			pre_on_ff   <= nxt_pre_on;
			pre_cfg_ff  <= nxt_pre_cfg;
			pchar_lo_ff <= nxt_pchar_lo;
			pchar_hi_ff <= nxt_pchar_hi;
			rdata_ff    <= nxt_rdata;
		end
	end

	assign reg_rdata = rdata_ff;

	// control hand-off to the stream side; depth sets start and inject latency
	logic [sync_stage_depth-1:0] en_sync_ff, nxt_en_sync;
	logic [sync_stage_depth-1:0] inj_sync_ff, nxt_inj_sync;

	always_comb begin
		nxt_en_sync  = {en_sync_ff[sync_stage_depth-2:0], gen_en_ff};
		nxt_inj_sync = {inj_sync_ff[sync_stage_depth-2:0], inj_launch};
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			en_sync_ff  <= '0;
			inj_sync_ff <= '0;
		end else if (clk_en) begin
			en_sync_ff  <= nxt_en_sync;
			inj_sync_ff <= nxt_inj_sync;
		end
	end

	// stream group
	logic                  run_d_ff, nxt_run_d;
	logic [LFSR_W-1:0]     lfsr_ff, nxt_lfsr;
	logic [PRE_CNT_W-1:0]  pre_left_ff, nxt_pre_left;
	logic                  err_pend_ff, nxt_err_pend;
	logic [STREAM_W-1:0]   data_ff, nxt_data;
	logic                  valid_ff, nxt_valid;
	logic                  run;
	logic                  advance;
	logic                  inj_arrive;
	logic                  pre_active;
	logic [PRE_CNT_W-1:0]  pre_cnt;
	logic [STREAM_W-1:0]   pre_word;
	logic [STREAM_W-1:0]   pat_word;
	logic [LFSR_W+STREAM_W-1:0] prbs_res;

	always_comb begin
		// enable drop takes effect at once so the stream stops on the next edge
		run        = en_sync_ff[sync_stage_depth-1] & gen_en_ff;
		advance    = !valid_ff || stream_ready;
		inj_arrive = inj_sync_ff[sync_stage_depth-1];
		pre_word   = {pchar_hi_ff, pchar_lo_ff};
		pre_cnt    = (run && !run_d_ff) ? (pre_on_ff ? pre_cfg_ff : '0) : pre_left_ff;
		pre_active = pre_cnt != '0;
		prbs_res   = '0;
		pat_word   = IDLE_WORD;
		// one-hot select; any other mix falls to the first bit set
		if (pat_sel_ff[SEL_PRBS7]) begin
			prbs_res = prbs_beat(lfsr_ff, P7_LEN, P7_TAP);
			pat_word = prbs_res[STREAM_W-1:0];
		end else if (pat_sel_ff[SEL_PRBS15]) begin
			prbs_res = prbs_beat(lfsr_ff, P15_LEN, P15_TAP);
			pat_word = prbs_res[STREAM_W-1:0];
		end else if (pat_sel_ff[SEL_PRBS23]) begin
			prbs_res = prbs_beat(lfsr_ff, P23_LEN, P23_TAP);
			pat_word = prbs_res[STREAM_W-1:0];
		end else if (pat_sel_ff[SEL_PRBS31]) begin
			prbs_res = prbs_beat(lfsr_ff, P31_LEN, P31_TAP);
			pat_word = prbs_res[STREAM_W-1:0];
		end else if (pat_sel_ff[SEL_HIGH_FREQ]) begin
			pat_word = HIGH_FREQ_WORD;
		end else if (pat_sel_ff[SEL_LOW_FREQ]) begin
			pat_word = LOW_FREQ_WORD;
		end
		nxt_run_d    = run;
		nxt_lfsr     = lfsr_ff;
		nxt_pre_left = pre_left_ff;
		nxt_err_pend = err_pend_ff;
		nxt_data     = data_ff;
		nxt_valid    = valid_ff;
		if (!run) begin
			// a pending error dies with the run
			nxt_valid    = 1'b0;
			nxt_data     = IDLE_WORD;
			nxt_lfsr     = LFSR_SEED;
			nxt_pre_left = '0;
			nxt_err_pend = 1'b0;
		end else if (advance) begin
			nxt_valid    = 1'b1;
			nxt_err_pend = 1'b0;
			if (pre_active) begin
				nxt_data     = pre_word;
				nxt_pre_left = pre_cnt - 1'b1;
			end else begin
				nxt_data     = pat_word;
				nxt_pre_left = '0;
				if (pat_sel_ff[SEL_PRBS31:SEL_PRBS7] != '0) begin
					nxt_lfsr = prbs_res[LFSR_W+STREAM_W-1:STREAM_W];
				end
			end
			nxt_data[0] = nxt_data[0] ^ (err_pend_ff | inj_arrive);
		end else begin
			// a stalled beat is never altered; the error waits for the next one
			nxt_err_pend = err_pend_ff | inj_arrive;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			run_d_ff    <= 1'b0;
			lfsr_ff     <= LFSR_SEED;
			pre_left_ff <= '0;
			err_pend_ff <= 1'b0;
			data_ff     <= IDLE_WORD;
			valid_ff    <= 1'b0;
		end else if (clk_en) begin
			run_d_ff    <= nxt_run_d;
			lfsr_ff     <= nxt_lfsr;
			pre_left_ff <= nxt_pre_left;
			err_pend_ff <= nxt_err_pend;
			data_ff     <= nxt_data;
			valid_ff    <= nxt_valid;
		end
	end

	assign stream_data  = data_ff;
	assign stream_valid = valid_ff;

	default clocking dpg_cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	sequence enable_start_s;
		$rose(gen_en_ff) && clk_en ##1 (clk_en && gen_en_ff) [*2];
	endsequence

	start_latency_a: assert property (enable_start_s |=> stream_valid)
		else $error("first beat not valid on fourth cycle");
	no_early_valid_a: assert property ($rose(gen_en_ff) && clk_en |=> !stream_valid)
		else $error("beat valid too early after enable");
	stop_next_a: assert property ($fell(gen_en_ff) && clk_en |=> !stream_valid)
		else $error("stream still valid after disable");
	enable_write_a: assert property (reg_write && clk_en && reg_addr == OFS_ENABLE
		|=> gen_en_ff == $past(reg_wdata[EN_BIT]))
		else $error("enable write not taken");
	locked_write_a: assert property (reg_write && clk_en && gen_en_ff && reg_addr == OFS_PATTERN
		|=> $stable(pat_sel_ff))
		else $error("pattern select changed while enabled");
	inject_clear_a: assert property (inj_ff && gen_en_ff && clk_en && !(reg_write && reg_addr == OFS_INJECT)
		|=> !inj_ff)
		else $error("inject bit did not self clear");
	reserved_zero_a: assert property (reg_read && clk_en && reg_addr == OFS_PRE_CTRL
		|=> reg_rdata[PRE_CNT_LSB-1:1] == '0 && reg_rdata[REG_DW-1:PRE_CNT_LSB+PRE_CNT_W] == '0)
		else $error("reserved bits read non zero");
	preamble_word_a: assert property (run && advance && pre_active && clk_en && !inj_arrive && !err_pend_ff
		|=> stream_data == $past(pre_word))
		else $error("preamble word not sent");
	high_freq_word_a: assert property (run && advance && !pre_active && clk_en
		&& pat_sel_ff == (PAT_W'(1'h1) << SEL_HIGH_FREQ)
		|=> stream_data[STREAM_W-1:1] == HIGH_FREQ_WORD[STREAM_W-1:1])
		else $error("high frequency word wrong");
	low_freq_word_a: assert property (run && advance && !pre_active && clk_en
		&& pat_sel_ff == (PAT_W'(1'h1) << SEL_LOW_FREQ)
		|=> stream_data[STREAM_W-1:1] == LOW_FREQ_WORD[STREAM_W-1:1])
		else $error("low frequency word wrong");
	stall_hold_a: assert property (stream_valid && !stream_ready && gen_en_ff && clk_en
		|=> $stable(stream_data))
		else $error("stalled beat changed");

endmodule // dpg_generator
`default_nettype wire

// ---- include/dpg_pkg.sv ----
`default_nettype none
package dpg_pkg;
	// stream and symbol shape
	localparam int STREAM_W      = 40;
	localparam int SYMS_PER_BEAT = 4;
	localparam int SYM_W         = STREAM_W / SYMS_PER_BEAT;
	localparam int SYNC_DEPTH    = 2;
	// register port
	localparam int REG_AW = 3;
	localparam int REG_DW = 32;
	localparam logic [REG_AW-1:0] OFS_ENABLE   = 3'h0;
	localparam logic [REG_AW-1:0] OFS_PATTERN  = 3'h1;
	localparam logic [REG_AW-1:0] OFS_INJECT   = 3'h2;
	localparam logic [REG_AW-1:0] OFS_PRE_CTRL = 3'h3;
	localparam logic [REG_AW-1:0] OFS_PCHAR_LO = 3'h4;
	localparam logic [REG_AW-1:0] OFS_PCHAR_HI = 3'h5;
	// fields
	localparam int EN_BIT      = 0;
	localparam int INJ_BIT     = 0;
	localparam int PRE_ON_BIT  = 0;
	localparam int PRE_CNT_LSB = 8;
	localparam int PRE_CNT_W   = 8;
	localparam int PCHAR_HI_W  = 8;
	localparam int PAT_W       = 6;
	localparam int SEL_PRBS7   = 0;
	localparam int SEL_PRBS15  = 1;
	localparam int SEL_PRBS23  = 2;
	localparam int SEL_PRBS31  = 3;
	localparam int SEL_HIGH_FREQ = 4;
	localparam int SEL_LOW_FREQ  = 5;
	// prbs lengths and taps
	localparam int LFSR_W   = 31;
	localparam int P7_LEN   = 7;
	localparam int P7_TAP   = 6;
	localparam int P15_LEN  = 15;
	localparam int P15_TAP  = 14;
	localparam int P23_LEN  = 23;
	localparam int P23_TAP  = 18;
	localparam int P31_LEN  = 31;
	localparam int P31_TAP  = 28;
	localparam logic [LFSR_W-1:0] LFSR_SEED = 31'h7fffffff;
	// fixed words
	localparam logic [STREAM_W-1:0] HIGH_FREQ_WORD = {(STREAM_W/2){2'h1}};
	localparam logic [STREAM_W-1:0] IDLE_WORD      = HIGH_FREQ_WORD;
	localparam logic [SYM_W-1:0]    LOW_FREQ_SYM   = {{(SYM_W/2){1'b1}}, {(SYM_W/2){1'b0}}};
	localparam logic [STREAM_W-1:0] LOW_FREQ_WORD  = {SYMS_PER_BEAT{LOW_FREQ_SYM}};
endpackage
`default_nettype wire

// ---- testbench/dpg_sink_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module dpg_sink_model (
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	// stream from the generator
	input  wire logic        stream_valid,
	output logic             stream_ready,
	// bench control and observation
	input  wire logic        stall,
	output logic      [31:0] beat_count
);
	logic        ready_ff;
	logic        nxt_ready;
	logic [31:0] beats_ff;
	logic [31:0] nxt_beats;
	// ready is registered, so a stall request takes effect one edge late, like a real sink
	always_comb begin
		nxt_ready = !stall;
		nxt_beats = beats_ff + {31'h0, stream_valid & ready_ff};
	end
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ready_ff <= 1'b0;
			beats_ff <= 32'h0;
		end else begin
			ready_ff <= nxt_ready;
			beats_ff <= nxt_beats;
		end
	end
	assign stream_ready = ready_ff;
	assign beat_count   = beats_ff;
endmodule // dpg_sink_model
`default_nettype wire

// ---- testbench/tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb
	import dpg_pkg::*;
;
	logic                core_clk;
	logic                rst_n;
	logic [REG_AW-1:0]   reg_addr;
	logic                reg_write;
	logic [REG_DW-1:0]   reg_wdata;
	logic                reg_read;
	logic [REG_DW-1:0]   reg_rdata;
	logic [STREAM_W-1:0] stream_data;
	logic                stream_valid;
	logic                stream_ready;
	logic                stall;
	logic [31:0]         beat_count;
	logic                clk_en;
	logic [31:0]         bc;
	int                  miscompares;
	int                  checked;
	int                  cycles;
	logic [30:0]         st;
	logic [39:0]         b0;
	logic [39:0]         b1;
	logic [39:0]         b2;
	int                  lens [4];
	int                  taps [4];

	dpg_generator dpg_generator_inst (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .reg_addr(reg_addr),
		.reg_write(reg_write), .reg_wdata(reg_wdata), .reg_read(reg_read), .reg_rdata(reg_rdata),
		.stream_data(stream_data), .stream_valid(stream_valid), .stream_ready(stream_ready));
	dpg_sink_model dpg_sink_model_inst (.core_clk(core_clk), .rst_n(rst_n), .stream_valid(stream_valid),
		.stream_ready(stream_ready), .stall(stall), .beat_count(beat_count));

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [REG_AW-1:0] a, input logic [REG_DW-1:0] d);
		// a free edge before each access keeps back-to-back strobes apart
		@(negedge core_clk);
		reg_addr = a;
		reg_wdata = d;
		reg_write = 1'b1;
		@(posedge core_clk);
		@(negedge core_clk);
		reg_write = 1'b0;
	endtask

	task automatic rd(input logic [REG_AW-1:0] a, input logic [REG_DW-1:0] exp);
		@(negedge core_clk);
		reg_addr = a;
		reg_read = 1'b1;
		@(posedge core_clk);
		@(negedge core_clk);
		reg_read = 1'b0;
		chk({8'h0, reg_rdata}, {8'h0, exp});
	endtask

	// enable, then the first beat must land exactly in the fourth cycle
	task automatic go();
		wr(OFS_ENABLE, 32'h1);
		repeat (3) begin
			chk({39'h0, stream_valid}, 40'h0);
			@(negedge core_clk);
		end
		chk({39'h0, stream_valid}, 40'h1);
	endtask

	// valid lasts one more cycle after the disabling write, then idle
	task automatic stop();
		wr(OFS_ENABLE, 32'h0);
		chk({39'h0, stream_valid}, 40'h1);
		@(negedge core_clk);
		chk({39'h0, stream_valid}, 40'h0);
		chk(stream_data, IDLE_WORD);
	endtask

	// fibonacci reference: each feedback bit is one output bit, msb first
	task automatic nxt_beat(input int n, input int t, inout logic [30:0] s, output logic [39:0] b);
		logic f;
		for (int i = 39; i >= 0; i--) begin
			f = s[n-1] ^ s[t-1];
			s = {s[29:0], f};
			b[i] = f;
		end
	endtask

	task automatic end_of_test();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 5000) begin
			miscompares++;
			end_of_test();
		end
	end

	initial begin
		rst_n = 1'b0;
		reg_addr = '0;
		reg_write = 1'b0;
		reg_wdata = '0;
		reg_read = 1'b0;
		stall = 1'b0;
		clk_en = 1'b1;
		miscompares = 0;
		checked = 0;
		cycles = 0;
		lens = '{P7_LEN, P15_LEN, P23_LEN, P31_LEN};
		taps = '{P7_TAP, P15_TAP, P23_TAP, P31_TAP};
		repeat (8) @(negedge core_clk);
		rst_n = 1'b1;
		@(negedge core_clk);
		for (int a = 0; a < 8; a++) rd(a[REG_AW-1:0], 32'h0);
		// each prbs mode, with a sink stall after the first beat
		for (int m = 0; m < 4; m++) begin
			wr(OFS_PATTERN, 32'h1 << m);
			st = LFSR_SEED;
			nxt_beat(lens[m], taps[m], st, b0);
			nxt_beat(lens[m], taps[m], st, b1);
			nxt_beat(lens[m], taps[m], st, b2);
			go();
			chk(stream_data, b0);
			stall = 1'b1;
			@(negedge core_clk);
			chk(stream_data, b1);
			repeat (3) @(negedge core_clk);
			chk({39'h0, stream_valid}, 40'h1);
			chk(stream_data, b1);
			stall = 1'b0;
			repeat (2) @(negedge core_clk);
			chk(stream_data, b2);
			stop();
		end
		// preamble programmed while idle, reserved bits set on purpose
		wr(OFS_PRE_CTRL, 32'hffff_0301);
		rd(OFS_PRE_CTRL, 32'h0000_0301);
		wr(OFS_PCHAR_LO, 32'h1234_5678);
		wr(OFS_PCHAR_HI, 32'hffff_ff9a);
		rd(OFS_PCHAR_HI, 32'h0000_009a);
		wr(OFS_PATTERN, 32'hffff_ff10);
		rd(OFS_PATTERN, 32'h0000_0010);
		go();
		repeat (3) begin
			chk(stream_data, 40'h9a_1234_5678);
			@(negedge core_clk);
		end
		chk(stream_data, HIGH_FREQ_WORD);
		wr(OFS_PATTERN, 32'h20);
		wr(OFS_PCHAR_LO, 32'h0);
		rd(OFS_PATTERN, 32'h10);
		rd(OFS_PCHAR_LO, 32'h1234_5678);
		wr(OFS_INJECT, 32'h1);
		repeat (2) @(negedge core_clk);
		chk(stream_data, HIGH_FREQ_WORD);
		@(negedge core_clk);
		chk(stream_data, HIGH_FREQ_WORD ^ 40'h1);
		@(negedge core_clk);
		chk(stream_data, HIGH_FREQ_WORD);
		rd(OFS_INJECT, 32'h0);
		stop();
		wr(OFS_PRE_CTRL, 32'h0);
		wr(OFS_PATTERN, 32'h20);
		bc = beat_count;
		go();
		chk(stream_data, LOW_FREQ_WORD);
		stop();
		// two beats while enabled plus the final one after the disabling write
		chk({8'h0, beat_count}, {8'h0, bc + 32'h3});
		// a frozen core must not take the enabling write
		clk_en = 1'b0;
		wr(OFS_ENABLE, 32'h1);
		clk_en = 1'b1;
		rd(OFS_ENABLE, 32'h0);
		chk({39'h0, stream_valid}, 40'h0);
		end_of_test();
	end
endmodule // tb
`default_nettype wire
